// file: rtl/dspt_pkg.sv
// shared constants and types of the dual-slope pwm timer
package dspt_pkg;

    localparam int unsigned CW      = 16;
    localparam int unsigned PRE_W   = 10;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned MODE_W  = 4;
    localparam int unsigned OUTM_W  = 2;
    localparam int unsigned CS_W    = 3;
    localparam int unsigned CTRL_W  = 11;
    localparam int unsigned FLG_W   = 4;
    localparam int unsigned DIR_W   = 2;

    // waveform mode select codes
    localparam logic [3:0] MODE_PC_8     = 4'h1;
    localparam logic [3:0] MODE_PC_9     = 4'h2;
    localparam logic [3:0] MODE_PC_10    = 4'h3;
    localparam logic [3:0] MODE_PFC_CAPT = 4'h8;
    localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
    localparam logic [3:0] MODE_PC_CAPT  = 4'hA;
    localparam logic [3:0] MODE_PC_CMPA  = 4'hB;

    localparam logic [15:0] BOTTOM   = 16'h0000;
    localparam logic [15:0] TOP_8    = 16'h00FF;
    localparam logic [15:0] TOP_9    = 16'h01FF;
    localparam logic [15:0] TOP_10   = 16'h03FF;
    localparam logic [15:0] MAXV     = 16'hFFFF;
    localparam logic [15:0] ONE      = 16'h0001;

    // compare output mode codes
    localparam logic [1:0] OUTM_NONINV = 2'h2;
    localparam logic [1:0] OUTM_INV    = 2'h3;

    // clock select codes and divider end counts
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] LAST_DIV1    = 10'h000;
    localparam logic [9:0] LAST_DIV8    = 10'h007;
    localparam logic [9:0] LAST_DIV64   = 10'h03F;
    localparam logic [9:0] LAST_DIV256  = 10'h0FF;
    localparam logic [9:0] LAST_DIV1024 = 10'h3FF;
    localparam logic [9:0] PRE_ZERO     = 10'h000;
    localparam logic [9:0] PRE_ONE      = 10'h001;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_DIR   = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMPA  = 8'h0C;
    localparam logic [7:0] OFS_CMPB  = 8'h10;
    localparam logic [7:0] OFS_CAPT  = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;

    // control field positions
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned OUTA_LSB = 4;
    localparam int unsigned OUTB_LSB = 6;
    localparam int unsigned CS_LSB   = 8;

    // flag and direction bit positions
    localparam int unsigned FLG_OVF  = 0;
    localparam int unsigned FLG_CMPA = 1;
    localparam int unsigned FLG_CMPB = 2;
    localparam int unsigned FLG_CAPT = 3;
    localparam int unsigned DIR_A    = 0;
    localparam int unsigned DIR_B    = 1;

    localparam logic [10:0] CTRL_RST  = 11'h000;
    localparam logic [3:0]  FLG_RST   = 4'h0;
    localparam logic [1:0]  DIR_RST   = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        KIND_OFF = 2'b00,
        KIND_PC  = 2'b01,
        KIND_PFC = 2'b10
    } dspt_kind_t;

    typedef enum logic [1:0] {
        TSRC_FIXED = 2'b00,
        TSRC_CAPT  = 2'b01,
        TSRC_CMPA  = 2'b10
    } dspt_tsrc_t;

    function automatic dspt_kind_t kind_of(input logic [3:0] m);
        kind_of = KIND_OFF;
        if (m == MODE_PC_8 || m == MODE_PC_9 || m == MODE_PC_10 ||
            m == MODE_PC_CAPT || m == MODE_PC_CMPA)
            kind_of = KIND_PC;
        else if (m == MODE_PFC_CAPT || m == MODE_PFC_CMPA)
            kind_of = KIND_PFC;
    endfunction

    function automatic dspt_tsrc_t tsrc_of(input logic [3:0] m);
        tsrc_of = TSRC_FIXED;
        if (m == MODE_PC_CAPT || m == MODE_PFC_CAPT)
            tsrc_of = TSRC_CAPT;
        else if (m == MODE_PC_CMPA || m == MODE_PFC_CMPA)
            tsrc_of = TSRC_CMPA;
    endfunction

    // fixed top of a mode, all ones where no fixed top applies
    function automatic logic [15:0] fixed_top(input logic [3:0] m);
        fixed_top = MAXV;
        if (m == MODE_PC_8)
            fixed_top = TOP_8;
        else if (m == MODE_PC_9)
            fixed_top = TOP_9;
        else if (m == MODE_PC_10)
            fixed_top = TOP_10;
    endfunction

endpackage

// file: rtl/dspt_prescale.sv
// prescaler producing the one-cycle timer clock enable
`timescale 1ns/100ps
`default_nettype none
module dspt_prescale
    import dspt_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // clock select
    input  wire logic [CS_W-1:0] cs,
    // timer clock enable
    output var  logic            tick
);
    logic [PRE_W-1:0] div_reg;
    logic [PRE_W-1:0] div_next;
    logic [PRE_W-1:0] last;
    logic             running;
    logic             wrap;
    logic             tick_reg;

    assign last = (cs == CS_DIV8)    ? LAST_DIV8 :
                  (cs == CS_DIV64)   ? LAST_DIV64 :
                  (cs == CS_DIV256)  ? LAST_DIV256 :
                  (cs == CS_DIV1024) ? LAST_DIV1024 : LAST_DIV1;
    assign running = (cs >= CS_DIV1) && (cs <= CS_DIV1024);
    // >= so a switch to a shorter ratio never runs the full range
    assign wrap     = div_reg >= last;
    assign div_next = (!running || wrap) ? PRE_ZERO : div_reg + PRE_ONE;
    assign tick     = tick_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg  <= PRE_ZERO;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg  <= div_next;
            tick_reg <= running && wrap; // R18
        end
    end
endmodule
`default_nettype wire

// file: rtl/dspt_chan.sv
// one compare channel: active compare value, match and waveform
`timescale 1ns/100ps
`default_nettype none
module dspt_chan
    import dspt_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // counter side
    input  wire logic          tick,
    input  wire logic          load,
    input  wire logic          eff_up,
    input  wire logic [CW-1:0] cnt,
    input  wire logic [CW-1:0] buf_val,
    // results
    output var  logic [CW-1:0] cmp_act,
    output var  logic          match,
    output var  logic          wave
);
    logic [CW-1:0] act_reg;
    logic          wave_reg;

    assign match   = tick && (cnt == act_reg); // R09
    assign cmp_act = act_reg;
    assign wave    = wave_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_reg  <= BOTTOM;
            wave_reg <= 1'b0;
        end
        else
        begin
            if (load)
                act_reg <= buf_val; // R20
            // non-inverted sense: low after up match, high after down
            if (match)
                wave_reg <= !eff_up; // R04 R11
        end
    end
endmodule
`default_nettype wire

// file: rtl/dspt_top.sv
// dual-slope pwm timer with ahb-lite register slave
//
// Contract
// R01 - modes 1,2,3,10,11 run phase correct: count up to TOP, then down.
// R02 - phase correct TOP is 0xFF, 0x1FF, 0x3FF, capture value or compare A.
// R03 - counter holds TOP exactly one timer tick, then counts down.
// R04 - non-inverted clears on up match, sets on down match; inverted opposite.
// R05 - output mode two is non-inverted, three is inverted pwm.
// R06 - waveform drives the pin only when its direction bit is output.
// R07 - phase correct sets the overflow flag at BOTTOM.
// R08 - phase correct loads compare buffers at TOP; TOP source flag set then.
// R09 - compare flag set on every match; flags offered as interrupt sources.
// R10 - fixed TOP modes zero unused upper bits of written compare values.
// R11 - compare at BOTTOM gives constant low, at TOP constant high.
// R12 - modes 8 and 9 run phase and frequency correct, TOP capture or A.
// R13 - frequency correct loads compare buffers at BOTTOM, overflow then.
// R14 - frequency correct sets the TOP source flag when TOP is reached.
// R15 - software keeps new TOP at or above every compare value.
// R16 - phase correct periods start and end at TOP.
// R17 - software should prefer frequency correct mode when changing TOP.
// R18 - output frequency is clock over twice prescale times TOP.
// R19 - TOP may range from 0x0003 up to the full 16-bit count.
// R20 - compare writes go to a buffer, loaded at the update point.
// R21 - capture value is unbuffered and acts as TOP at once.
// R22 - counter steps only on the prescaler timer enable.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module dspt_top
    import dspt_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic        HREADY,
    input  wire logic [31:0] HWDATA,
    output var  logic [31:0] HRDATA,
    output var  logic        HREADYOUT,
    output var  logic        HRESP,
    // compare output pins
    output var  logic        PIN_A_OUT,
    output var  logic        PIN_A_OE_N,
    output var  logic        PIN_B_OUT,
    output var  logic        PIN_B_OE_N,
    // flag levels for an interrupt controller
    output var  logic [3:0]  FLAGS
);
    logic [CTRL_W-1:0] ctrl_reg;
    logic [DIR_W-1:0]  dir_reg;
    logic [FLG_W-1:0]  flags_reg;
    logic [FLG_W-1:0]  flags_next;
    logic [CW-1:0]     cnt_reg;
    logic [CW-1:0]     cnt_next;
    logic              dir_up_reg;
    logic [CW-1:0]     cmpa_buf_reg;
    logic [CW-1:0]     cmpb_buf_reg;
    logic [CW-1:0]     capt_reg;
    logic              wr_pend_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [31:0]       hrdata_reg;
    logic              pin_a_reg;
    logic              pin_a_oe_n_reg;
    logic              pin_b_reg;
    logic              pin_b_oe_n_reg;

    // field views
    logic [MODE_W-1:0] mode;
    logic [OUTM_W-1:0] outm_a;
    logic [OUTM_W-1:0] outm_b;
    logic [CS_W-1:0]   cs;
    dspt_kind_t        kind;
    dspt_tsrc_t        tsrc;
    logic [CW-1:0]     wmask;

    assign mode   = ctrl_reg[MODE_LSB +: MODE_W];
    assign outm_a = ctrl_reg[OUTA_LSB +: OUTM_W];
    assign outm_b = ctrl_reg[OUTB_LSB +: OUTM_W];
    assign cs     = ctrl_reg[CS_LSB +: CS_W];
    assign kind   = kind_of(mode); // R01 R12
    assign tsrc   = tsrc_of(mode);
    assign wmask  = fixed_top(mode);

    // bus decode
    logic        addr_ok;
    logic        rd_take;
    logic [31:0] rd_word;
    logic        wr_ctrl;
    logic        wr_dir;
    logic        wr_cnt;
    logic        wr_cmpa;
    logic        wr_cmpb;
    logic        wr_capt;
    logic        wr_flags;
    logic [CW-1:0] wdata16;

    assign addr_ok = HSEL && HREADY && HTRANS[1];
    assign rd_take = addr_ok && !HWRITE;
    assign wdata16 = HWDATA[CW-1:0];
    assign wr_ctrl  = wr_pend_reg && (addr_reg == OFS_CTRL);
    assign wr_dir   = wr_pend_reg && (addr_reg == OFS_DIR);
    assign wr_cnt   = wr_pend_reg && (addr_reg == OFS_COUNT);
    assign wr_cmpa  = wr_pend_reg && (addr_reg == OFS_CMPA);
    assign wr_cmpb  = wr_pend_reg && (addr_reg == OFS_CMPB);
    assign wr_capt  = wr_pend_reg && (addr_reg == OFS_CAPT);
    assign wr_flags = wr_pend_reg && (addr_reg == OFS_FLAGS);

    // unmapped offsets read as zero
    assign rd_word =
        (HADDR[ADDR_W-1:0] == OFS_CTRL)  ? {21'h00_0000, ctrl_reg} :
        (HADDR[ADDR_W-1:0] == OFS_DIR)   ? {30'h0000_0000, dir_reg} :
        (HADDR[ADDR_W-1:0] == OFS_COUNT) ? {16'h0000, cnt_reg} :
        (HADDR[ADDR_W-1:0] == OFS_CMPA)  ? {16'h0000, cmpa_buf_reg} :
        (HADDR[ADDR_W-1:0] == OFS_CMPB)  ? {16'h0000, cmpb_buf_reg} :
        (HADDR[ADDR_W-1:0] == OFS_CAPT)  ? {16'h0000, capt_reg} :
        (HADDR[ADDR_W-1:0] == OFS_FLAGS) ? {28'h000_0000, flags_reg} :
        WORD_ZERO;

    // timer enable and channels
    logic          tick;
    logic          run;
    logic          tick_run;
    logic [CW-1:0] cmpa_act;
    logic [CW-1:0] cmpb_act;
    logic          match_a;
    logic          match_b;
    logic          wave_a;
    logic          wave_b;
    logic [CW-1:0] top_val;
    logic          at_top;
    logic          at_bot;
    logic          eff_up;
    logic          load;

    assign run      = (kind != KIND_OFF);
    assign tick_run = tick && run; // R22
    // capture value feeds TOP straight, no buffer
    assign top_val  = (tsrc == TSRC_CAPT) ? capt_reg :  // R21
                      (tsrc == TSRC_CMPA) ? cmpa_act : wmask; // R02 R12
    assign at_top   = (cnt_reg == top_val);
    assign at_bot   = (cnt_reg == BOTTOM);
    // TOP cycle counts as falling, BOTTOM as rising
    assign eff_up   = at_bot || (dir_up_reg && !at_top); // R03 R11
    assign load     = tick_run && ((kind == KIND_PC) ? at_top : at_bot); // R08 R13 R16

    // a lowered capture TOP below the count runs on to MAXV and wraps
    assign cnt_next = wr_cnt ? wdata16 :
                      !tick_run ? cnt_reg :
                      eff_up ? cnt_reg + ONE : cnt_reg - ONE; // R01 R19

    // set wins over a software clear in the same cycle
    logic [FLG_W-1:0] flg_set;
    logic [FLG_W-1:0] flg_clr;

    assign flg_set[FLG_OVF]  = tick_run && at_bot; // R07 R13
    assign flg_set[FLG_CMPA] = match_a ||
                               (tick_run && at_top && tsrc == TSRC_CMPA); // R08 R14
    assign flg_set[FLG_CMPB] = match_b; // R09
    assign flg_set[FLG_CAPT] = tick_run && at_top && tsrc == TSRC_CAPT; // R08 R14
    assign flg_clr    = wr_flags ? HWDATA[FLG_W-1:0] : FLG_RST;
    assign flags_next = (flags_reg & ~flg_clr) | flg_set;

    dspt_prescale u_pre (
        .clk   (CLK),
        .rst_n (RST_N),
        .cs    (cs),
        .tick  (tick)
    );

    dspt_chan u_chan_a (
        .clk     (CLK),
        .rst_n   (RST_N),
        .tick    (tick_run),
        .load    (load),
        .eff_up  (eff_up),
        .cnt     (cnt_reg),
        .buf_val (cmpa_buf_reg),
        .cmp_act (cmpa_act),
        .match   (match_a),
        .wave    (wave_a)
    );

    dspt_chan u_chan_b (
        .clk     (CLK),
        .rst_n   (RST_N),
        .tick    (tick_run),
        .load    (load),
        .eff_up  (eff_up),
        .cnt     (cnt_reg),
        .buf_val (cmpb_buf_reg),
        .cmp_act (cmpb_act),
        .match   (match_b),
        .wave    (wave_b)
    );

    // pin drive
    logic conn_a;
    logic conn_b;
    logic lvl_a;
    logic lvl_b;

    assign conn_a = (outm_a == OUTM_NONINV) || (outm_a == OUTM_INV); // R05
    assign conn_b = (outm_b == OUTM_NONINV) || (outm_b == OUTM_INV); // R05
    assign lvl_a  = conn_a && ((outm_a == OUTM_INV) ? !wave_a : wave_a);
    assign lvl_b  = conn_b && ((outm_b == OUTM_INV) ? !wave_b : wave_b);

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= OFS_CTRL;
            hrdata_reg  <= WORD_ZERO;
        end
        else
        begin
            wr_pend_reg <= addr_ok && HWRITE;
            if (addr_ok)
                addr_reg <= HADDR[ADDR_W-1:0];
            if (rd_take)
                hrdata_reg <= rd_word;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_reg     <= CTRL_RST;
            dir_reg      <= DIR_RST;
            cmpa_buf_reg <= BOTTOM;
            cmpb_buf_reg <= BOTTOM;
            capt_reg     <= BOTTOM;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= HWDATA[CTRL_W-1:0];
            if (wr_dir)
                dir_reg <= HWDATA[DIR_W-1:0];
            if (wr_cmpa)
                cmpa_buf_reg <= wdata16 & wmask; // R10 R20
            if (wr_cmpb)
                cmpb_buf_reg <= wdata16 & wmask; // R10 R20
            if (wr_capt)
                capt_reg <= wdata16; // R21
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cnt_reg    <= BOTTOM;
            dir_up_reg <= 1'b1;
            flags_reg  <= FLG_RST;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            flags_reg <= flags_next;
            if (tick_run)
                dir_up_reg <= eff_up; // R03
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pin_a_reg      <= 1'b0;
            pin_a_oe_n_reg <= 1'b1;
            pin_b_reg      <= 1'b0;
            pin_b_oe_n_reg <= 1'b1;
        end
        else
        begin
            pin_a_reg      <= lvl_a;
            pin_a_oe_n_reg <= !(conn_a && dir_reg[DIR_A]); // R06
            pin_b_reg      <= lvl_b;
            pin_b_oe_n_reg <= !(conn_b && dir_reg[DIR_B]); // R06
        end
    end

    assign HRDATA     = hrdata_reg;
    assign HREADYOUT  = 1'b1;
    assign HRESP      = 1'b0;
    assign PIN_A_OUT  = pin_a_reg;
    assign PIN_A_OE_N = pin_a_oe_n_reg;
    assign PIN_B_OUT  = pin_b_reg;
    assign PIN_B_OE_N = pin_b_oe_n_reg;
    assign FLAGS      = flags_reg; // R09

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_reach_top;
        tick_run && at_top && dir_up_reg && !wr_cnt && !at_bot;
    endsequence

    property p_top_once;
        s_reach_top |=> (cnt_reg == $past(top_val) - ONE) && !dir_up_reg;
    endproperty
    a_top_once: assert property (p_top_once) // R03
        else $error("counter did not turn after one top tick");

    property p_ovf_bottom;
        tick_run && at_bot |=> flags_reg[FLG_OVF];
    endproperty
    a_ovf_bottom: assert property (p_ovf_bottom) // R07
        else $error("overflow flag missing at bottom");

    property p_pc_load;
        tick_run && at_top && kind == KIND_PC
            |=> cmpb_act == $past(cmpb_buf_reg);
    endproperty
    a_pc_load: assert property (p_pc_load) // R08
        else $error("compare not loaded at top");

    property p_pfc_load;
        tick_run && at_bot && kind == KIND_PFC
            |=> cmpb_act == $past(cmpb_buf_reg) && flags_reg[FLG_OVF];
    endproperty
    a_pfc_load: assert property (p_pfc_load) // R13
        else $error("compare or overflow not updated at bottom");

    property p_up_clear;
        match_a && eff_up && outm_a == OUTM_NONINV ##1 !match_a
            |=> !PIN_A_OUT;
    endproperty
    a_up_clear: assert property (p_up_clear) // R04
        else $error("pin not low after up match");

    property p_dir_gate;
        !dir_reg[DIR_A] |=> PIN_A_OE_N;
    endproperty
    a_dir_gate: assert property (p_dir_gate) // R06
        else $error("pin driven while direction is input");

    property p_mask;
        wr_cmpa && tsrc == TSRC_FIXED
            |=> (cmpa_buf_reg & ~$past(wmask)) == BOTTOM;
    endproperty
    a_mask: assert property (p_mask) // R10
        else $error("unused compare bits kept");

    property p_capt_now;
        wr_capt |=> capt_reg == $past(wdata16);
    endproperty
    a_capt_now: assert property (p_capt_now) // R21
        else $error("capture write not immediate");

    property p_step_gate;
        !tick_run && !wr_cnt |=> $stable(cnt_reg);
    endproperty
    a_step_gate: assert property (p_step_gate) // R22
        else $error("counter moved without timer enable");

    property p_capt_flag;
        tick_run && at_top && tsrc == TSRC_CAPT |=> flags_reg[FLG_CAPT];
    endproperty
    a_capt_flag: assert property (p_capt_flag) // R14
        else $error("capture flag missing at top");

    property p_match_flag;
        match_b |=> flags_reg[FLG_CMPB];
    endproperty
    a_match_flag: assert property (p_match_flag) // R09
        else $error("compare flag missing on match");
endmodule
`default_nettype wire

// file: tb/dspt_pins.sv
// pin loads with pull-ups on both compare output pins
`timescale 1ns/100ps
`default_nettype none
module dspt_pins
(
    // driver side
    input  wire logic a_out,
    input  wire logic a_oe_n,
    input  wire logic b_out,
    input  wire logic b_oe_n,
    // wire levels
    output wire logic a_lvl,
    output wire logic b_lvl
);
    // released pin floats up to the pull-up, never keeps the last level
    assign a_lvl = a_oe_n ? 1'b1 : a_out;
    assign b_lvl = b_oe_n ? 1'b1 : b_out;
endmodule
`default_nettype wire

// file: tb/test_dual_slope_pwm_timer.sv
// self-checking bench of the dual-slope pwm timer
`timescale 1ns/100ps
`default_nettype none
module test_dual_slope_pwm_timer
    import dspt_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = WORD_ZERO;
    logic        rd_dp = 1'b0;
    wire  logic [31:0] hrdata;
    wire  logic  hready;
    wire  logic  hresp;
    wire  logic  a_out;
    wire  logic  a_oe_n;
    wire  logic  b_out;
    wire  logic  b_oe_n;
    wire  logic  a_lvl;
    wire  logic  b_lvl;
    wire  logic [3:0] flags;
    int          bad_count = 0;
    int          n_compared = 0;
    integer      seed = 32'h0000_f678;
    int          t;
    int          c;
    logic [31:0] exp_q[$];
    int          nd[6] = '{0, 1, 8, 64, 256, 1024};
    logic [3:0]  fm[3] = '{MODE_PC_8, MODE_PC_9, MODE_PC_10};
    logic [15:0] ft[3] = '{TOP_8, TOP_9, TOP_10};
    logic [3:0]  rm[4] = '{MODE_PC_CAPT, MODE_PFC_CAPT, MODE_PFC_CMPA,
                           MODE_PC_CMPA};

    always #12.5 clk = ~clk;

    dspt_top uut
    (
        .CLK(clk),
        .RST_N(rst_n),
        .HSEL(hsel),
        .HADDR(haddr),
        .HTRANS(htrans),
        .HWRITE(hwrite),
        .HSIZE(3'h2),
        .HREADY(hready),
        .HWDATA(hwdata),
        .HRDATA(hrdata),
        .HREADYOUT(hready),
        .HRESP(hresp),
        .PIN_A_OUT(a_out),
        .PIN_A_OE_N(a_oe_n),
        .PIN_B_OUT(b_out),
        .PIN_B_OE_N(b_oe_n),
        .FLAGS(flags)
    );

    dspt_pins loads
    (
        .a_out(a_out),
        .a_oe_n(a_oe_n),
        .b_out(b_out),
        .b_oe_n(b_oe_n),
        .a_lvl(a_lvl),
        .b_lvl(b_lvl)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one single transfer; a read leaves its expectation for the watcher
    task automatic bus(input logic [7:0] a, input logic wr,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        if (!wr)
            exp_q.push_back(d);
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        if (rd_dp)
            check(hrdata, exp_q.pop_front());
        rd_dp <= hsel & htrans[1] & ~hwrite & hready;
    end

    // stop first so the old run cannot step during reprogramming
    task automatic cfg(input logic [3:0] m, input logic [1:0] om,
                       input logic [2:0] cs, input logic [15:0] tp,
                       input logic [15:0] cv);
        bus(OFS_CTRL, 1'b1, {21'h00_0000, 3'h0, om, om, m});
        bus(OFS_COUNT, 1'b1, WORD_ZERO);
        bus(OFS_CAPT, 1'b1, {16'h0000, tp});
        bus(OFS_CMPA, 1'b1, {16'h0000, tp});
        bus(OFS_CMPB, 1'b1, {16'h0000, cv});
        bus(OFS_CTRL, 1'b1, {21'h00_0000, cs, om, om, m});
    endtask

    task automatic lvl(input logic v);
        while (b_lvl !== v)
            @(negedge clk);
    endtask

    // first period skipped: buffers settle only at the first update point
    task automatic run(input logic [3:0] m, input logic [1:0] om,
                       input logic [2:0] cs, input int tp, input int cv);
        int hi;
        int lo;
        int n;
        n = nd[cs];
        cfg(m, om, cs, tp[15:0], cv[15:0]);
        lvl(1'b0);
        lvl(1'b1);
        lvl(1'b0);
        lvl(1'b1);
        hi = 0;
        lo = 0;
        while (b_lvl === 1'b1)
        begin
            @(negedge clk);
            hi++;
        end
        while (b_lvl === 1'b0)
        begin
            @(negedge clk);
            lo++;
        end
        check(32'(hi), 32'(om == OUTM_INV ? 2*(tp-cv)*n : 2*cv*n));
        check(32'(hi + lo), 32'(2*n*tp));
        check(32'(b_oe_n), 32'h0000_0000);
        check(32'(a_lvl), 32'(om != OUTM_INV));
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        check(32'(b_oe_n), 32'h0000_0001);
        check(32'(hresp), 32'h0000_0000);
        bus(OFS_CTRL, 1'b0, WORD_ZERO);
        bus(8'h1C, 1'b0, WORD_ZERO);
        bus(OFS_DIR, 1'b1, 32'h0000_0003);
        for (int k = 0; k < 3; k++)
        begin
            bus(OFS_CTRL, 1'b1, {28'h000_0000, fm[k]});
            bus(OFS_CMPB, 1'b1, 32'h0000_FFFF);
            bus(OFS_CMPB, 1'b0, {16'h0000, ft[k]});
            c = 1 + {$random(seed)} % (int'(ft[k]) - 1);
            run(fm[k], OUTM_NONINV, CS_DIV1, ft[k], c);
        end
        for (int k = 0; k < 8; k++)
        begin
            t = 3 + {$random(seed)} % 38;
            c = 1 + {$random(seed)} % (t - 1);
            run(rm[k % 4], k[2] ? OUTM_INV : OUTM_NONINV, CS_DIV1, t, c);
        end
        for (int s = 2; s < 6; s++)
            run(MODE_PFC_CAPT, OUTM_NONINV, s[2:0], 3, 1);
        for (int k = 0; k < 4; k++)
        begin
            cfg(MODE_PC_CAPT, k[0] ? OUTM_INV : OUTM_NONINV, CS_DIV1,
                16'h0005, k[1] ? 16'h0005 : BOTTOM);
            repeat (30) @(negedge clk);
            repeat (10)
            begin
                @(negedge clk);
                check(32'(b_lvl), 32'(k[0] ^ k[1]));
            end
        end
        bus(OFS_DIR, 1'b1, WORD_ZERO);
        repeat (3) @(negedge clk);
        check(32'(b_oe_n), 32'h0000_0001);
        cfg(MODE_PC_CAPT, OUTM_NONINV, 3'h0, 16'h0003, ONE);
        bus(OFS_FLAGS, 1'b1, 32'h0000_000F);
        repeat (20) @(negedge clk);
        bus(OFS_FLAGS, 1'b0, WORD_ZERO);
        bus(OFS_COUNT, 1'b0, WORD_ZERO);
        bus(OFS_CTRL, 1'b1, {21'h00_0000, CS_DIV1, 4'hA, MODE_PC_CAPT});
        repeat (30) @(negedge clk);
        check(32'(flags), 32'h0000_000F);
        stop_test;
    end

    // longest run is a few slow prescaler periods, well inside this span
    initial
    begin
        repeat (80000) @(posedge clk);
        bad_count++;
        stop_test;
    end
endmodule
`default_nettype wire
